// ==== sac_acq_ctrl.sv ====
// sac_acq_ctrl: converter acquisition control, polled and timed scan modes.
// assumes a converter front end on clk and a host memory port for DMA.
//
// The register addresses and register access over AHB-Lite were decided locally.
`timescale 1ns/10ps
module sac_acq_ctrl
  import sac_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic adc_start,
  output sac_entry_t adc_entry,
  input wire logic adc_done,
  input wire logic [15:0] adc_data,
  input wire logic external_timebase_input,
  input wire logic ext_trigger_input,
  output sac_mem_t mem,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata
);
  typedef enum logic [1:0] {S_IDLE, S_ARMED, S_RUN} sac_st_t;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction : hit

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [1:0] pin_rise;
  wire [1:0] pins = {ext_trigger_input, external_timebase_input};
  for (genvar g = 0; g < 2; g++) begin : g_sync
    logic [2:0] sh;
    logic lvl;
    logic lvl_d;
    always_ff @(posedge clk) begin
      if (!rstn) begin
        sh <= '0;
        lvl <= 1'b0;
        lvl_d <= 1'b0;
      end else begin
        sh <= {sh[1:0], pins[g]};
        if (sh[1] == sh[2]) begin
          lvl <= sh[2];
        end
        lvl_d <= lvl;
      end
    end
    assign pin_rise[g] = lvl & ~lvl_d;
  end

  // ----------------------------------------
  // AHB-Lite slave
  // ----------------------------------------
  logic wr;
  logic [7:0] wa;
  logic ctrl_tb_ext;
  logic ctrl_trig_ext;
  logic ctrl_chain;
  logic arm_p;
  logic abort_p;
  logic soft_trig_p;
  logic poll_go_p;
  sac_entry_t pcfg;
  logic [31:0] scan_int;
  logic [23:0] spacing;
  logic [30:0] post;
  logic [7:0] sps;
  logic [7:0] qidx;
  logic [31:0] dlo;
  logic [31:0] dhi;
  logic [31:0] dsize;
  logic [31:0] ddesc;
  sac_entry_t queue [256];
  logic poll_busy;
  logic poll_done;
  logic [15:0] poll_data;
  sac_st_t st;
  logic ovf;
  logic dma_busy;
  logic dma_done;
  logic dma_done_st;
  logic [31:0] dma_cnt;
  logic [31:0] rd_val;
  wire ahb_go = hsel & htrans[1] & hready;
  wire rd_go = ahb_go & ~hwrite;
  wire wctrl = wr & hit(wa, A_CTRL);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wr <= 1'b0;
      wa <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= '0;
    end else begin
      wr <= ahb_go & hwrite;
      if (ahb_go) begin
        wa <= haddr[7:0];
      end
      if (rd_go) begin
        hrdata <= rd_val;
      end
    end
  end

  always_comb begin
    case (haddr[7:0])
      A_CTRL: rd_val = {28'h0, ctrl_chain, ctrl_tb_ext, ctrl_trig_ext, st != S_IDLE};
      A_PCFG: rd_val = {24'h0, pcfg};
      A_PDATA: rd_val = {16'h0, poll_data};
      A_STAT: rd_val = {25'h0, dma_done_st, ovf, dma_busy, st == S_RUN, st == S_ARMED,
                        poll_done, poll_busy};
      A_SCAN: rd_val = scan_int;
      A_SPACE: rd_val = {8'h0, spacing};
      A_POST: rd_val = {1'b0, post};
      A_SPS: rd_val = {24'h0, sps};
      A_QIDX: rd_val = {24'h0, qidx};
      A_DLO: rd_val = dlo;
      A_DHI: rd_val = dhi;
      A_DSIZE: rd_val = dsize;
      A_DDESC: rd_val = ddesc;
      A_DCNT: rd_val = dma_cnt;
      default: rd_val = 32'h0;
    endcase
  end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl_tb_ext <= 1'b0;
      ctrl_trig_ext <= 1'b0;
      ctrl_chain <= 1'b0;
      pcfg <= '0;
      scan_int <= '0;
      spacing <= '0;
      post <= '0;
      sps <= '0;
      dlo <= '0;
      dhi <= '0;
      dsize <= '0;
      ddesc <= '0;
    end else if (wr) begin
      if (wctrl && st == S_IDLE) begin
        ctrl_trig_ext <= hwdata[C_TRIG_EXT];
        ctrl_tb_ext <= hwdata[C_TB_EXT];
        ctrl_chain <= hwdata[C_CHAIN];
      end
      if (hit(wa, A_PCFG)) pcfg <= hwdata[7:0];
      if (hit(wa, A_SCAN)) scan_int <= hwdata;
      if (hit(wa, A_SPACE)) spacing <= hwdata[23:0];
      if (hit(wa, A_POST)) post <= hwdata[30:0];
      if (hit(wa, A_SPS)) sps <= hwdata[7:0];
      if (hit(wa, A_DLO)) dlo <= hwdata;
      if (hit(wa, A_DHI)) dhi <= hwdata;
      if (hit(wa, A_DSIZE)) dsize <= hwdata;
      if (hit(wa, A_DDESC)) ddesc <= hwdata;
    end
  end

  // command strobes, one cycle each
  always_ff @(posedge clk) begin
    if (!rstn) begin
      arm_p <= 1'b0;
      abort_p <= 1'b0;
      soft_trig_p <= 1'b0;
      poll_go_p <= 1'b0;
    end else begin
      arm_p <= wctrl & hwdata[C_ARM] & (st == S_IDLE);
      abort_p <= wctrl & hwdata[C_ABORT];
      soft_trig_p <= wctrl & hwdata[C_SOFT_TRIG];
      poll_go_p <= wctrl & hwdata[C_POLL_GO];
    end
  end

  // channel/gain queue, index advances on each data write
  always_ff @(posedge clk) begin
    if (!rstn) begin
      qidx <= '0;
    end else if (wr && hit(wa, A_QIDX)) begin
      qidx <= hwdata[7:0];
    end else if (wr && hit(wa, A_QDAT)) begin
      qidx <= qidx + 8'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (wr && hit(wa, A_QDAT)) begin
      queue[qidx] <= hwdata[7:0];
    end
  end

  // ----------------------------------------
  // software polled conversion
  // ----------------------------------------
  wire poll_issue = poll_go_p & ~poll_busy & (st == S_IDLE);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      poll_busy <= 1'b0;
      poll_done <= 1'b0;
      poll_data <= '0;
    end else begin
      if (poll_issue) begin
        poll_busy <= 1'b1;
      end else if (poll_busy && adc_done) begin
        poll_busy <= 1'b0;
        poll_data <= adc_data;
      end
      // a completion in the cycle of the clearing read still sets done
      if (poll_busy && adc_done) begin
        poll_done <= 1'b1;
      end else if (rd_go && hit(haddr[7:0], A_PDATA)) begin
        poll_done <= 1'b0;
      end else if (poll_issue) begin
        poll_done <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // timed scan engine
  // ----------------------------------------
  logic [32:0] scan_el;
  logic [24:0] samp_el;
  logic [7:0] samp_idx;
  logic [30:0] scans;
  wire [2:0] step = ctrl_tb_ext ? {2'h0, pin_rise[0]} : INT_STEP;
  wire [32:0] scan_nx = scan_el + 33'(step);
  wire [24:0] samp_nx = samp_el + 25'(step);
  wire trig = ctrl_trig_ext ? pin_rise[1] : soft_trig_p;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st <= S_IDLE;
      scan_el <= '0;
      samp_el <= '0;
      samp_idx <= '0;
      scans <= '0;
      adc_start <= 1'b0;
      adc_entry <= '0;
    end else begin
      adc_start <= 1'b0;
      if (poll_issue) begin
        adc_start <= 1'b1;
        adc_entry <= pcfg;
      end
      case (st)
        S_IDLE: begin
          if (arm_p) st <= S_ARMED;
        end
        S_ARMED: begin
          if (abort_p) begin
            st <= S_IDLE;
          end else if (trig) begin
            st <= S_RUN;
            scan_el <= {1'b0, scan_int};
            samp_idx <= sps;
            scans <= '0;
          end
        end
        S_RUN: begin
          if (abort_p || (scans == post && samp_idx >= sps)) begin
            st <= S_IDLE;
          end else if (scan_nx >= {1'b0, scan_int}) begin
            // a short interval cuts an unfinished scan short
            scans <= scans + 31'h1;
            scan_el <= (scans == '0) ? '0 : scan_nx - {1'b0, scan_int};
            samp_idx <= 8'h1;
            samp_el <= '0;
            adc_start <= 1'b1;
            adc_entry <= queue[0];
          end else begin
            scan_el <= scan_nx;
            if (samp_idx < sps) begin
              if (samp_nx >= {1'b0, spacing}) begin
                samp_el <= samp_nx - {1'b0, spacing};
                samp_idx <= samp_idx + 8'h1;
                adc_start <= 1'b1;
                adc_entry <= queue[samp_idx];
              end else begin
                samp_el <= samp_nx;
              end
            end
          end
        end
        default: st <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // data FIFO toward DMA
  // ----------------------------------------
  logic [15:0] fifo_mem [2**FIFO_AW];
  logic [FIFO_AW:0] wp;
  logic [FIFO_AW:0] rp;
  logic fifo_pop;
  wire fifo_valid = wp != rp;
  wire fifo_full = (wp[FIFO_AW] != rp[FIFO_AW]) && (wp[FIFO_AW-1:0] == rp[FIFO_AW-1:0]);
  wire push = adc_done & ~poll_busy;

  always_ff @(posedge clk) begin
    if (push && !fifo_full) begin
      fifo_mem[wp[FIFO_AW-1:0]] <= adc_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wp <= '0;
      rp <= '0;
      ovf <= 1'b0;
      dma_done_st <= 1'b0;
    end else begin
      if (push && !fifo_full) wp <= wp + 1'b1;
      if (fifo_pop) rp <= rp + 1'b1;
      if (push && fifo_full) begin
        ovf <= 1'b1;
      end else if (arm_p) begin
        ovf <= 1'b0;
      end
      if (dma_done) begin
        dma_done_st <= 1'b1;
      end else if (arm_p) begin
        dma_done_st <= 1'b0;
      end
    end
  end

  sac_dma u_dma (
    .clk(clk),
    .rstn(rstn),
    .go(arm_p),
    .stop(abort_p),
    .chain(ctrl_chain),
    .addr_lo(dlo),
    .addr_hi(dhi),
    .size(dsize),
    .desc_ptr(ddesc),
    .fifo_valid(fifo_valid),
    .fifo_data(fifo_mem[rp[FIFO_AW-1:0]]),
    .fifo_pop(fifo_pop),
    .mem(mem),
    .mem_ack(mem_ack),
    .mem_rdata(mem_rdata),
    .busy(dma_busy),
    .done(dma_done),
    .count(dma_cnt)
  );
endmodule : sac_acq_ctrl

// ==== sac_acq_ctrl_asserts.sv ====
// sac_acq_ctrl_asserts: port checks of the acquisition controller.
// assumes it is bound onto sac_acq_ctrl and sees only its ports.
`timescale 1ns/10ps
module sac_acq_ctrl_asserts
  import sac_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic adc_start,
  input wire sac_entry_t adc_entry,
  input wire logic adc_done,
  input wire logic [15:0] adc_data,
  input wire logic external_timebase_input,
  input wire logic ext_trigger_input,
  input wire sac_mem_t mem,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_bus_ok; hreadyout && !hresp; endproperty
  a_bus_ok: assert property (p_bus_ok)
    else $error("bus slave stalled or answered with error");
  property p_start_pulse; adc_start |=> !adc_start [*2]; endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("conversion start longer than one cycle");
  property p_entry_hold; !adc_start |-> $stable(adc_entry); endproperty
  a_entry_hold: assert property (p_entry_hold)
    else $error("conversion entry changed without a start");
  property p_cfg_legal; adc_start |-> adc_entry.cfg != 2'h3; endproperty
  a_cfg_legal: assert property (p_cfg_legal)
    else $error("conversion started with unknown input configuration");
  property p_req_hold;
    mem.req && !mem_ack |=> mem.req && $stable(mem.addr) && $stable(mem.wdata);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("memory request dropped or changed before ack");
  property p_req_drop; mem.req && mem_ack |=> !mem.req; endproperty
  a_req_drop: assert property (p_req_drop)
    else $error("memory request still up after ack");
  property p_align; mem.req |-> mem.addr[1:0] == 2'h0; endproperty
  a_align: assert property (p_align)
    else $error("memory address not word aligned");
  property p_sign;
    mem.req && mem.we |-> mem.wdata[31:16] == {16{mem.wdata[15]}};
  endproperty
  a_sign: assert property (p_sign)
    else $error("result word not sign extended");
endmodule : sac_acq_ctrl_asserts

// ==== sac_acq_ctrl_bench.sv ====
// sac_acq_ctrl_bench: self-checking bench of the acquisition controller.
// assumes a 10 MHz clock, a 4-cycle converter model and the host memory model.
`timescale 1ns/10ps
module sac_acq_ctrl_bench
  import sac_pkg::*;
;
  logic clk, rstn, hsel, hwrite, hready, hreadyout, hresp, adc_start, adc_done, mem_ack;
  logic external_timebase_input, ext_trigger_input;
  logic [31:0] haddr, hwdata, hrdata, mem_rdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize, fe, tbdiv;
  logic [15:0] adc_data;
  logic [3:0] lag;
  sac_entry_t adc_entry;
  sac_mem_t mem;
  int n_mismatch, num_checks, cyc, fe_idx, n_wr;
  int t_q[$];
  sac_entry_t e_q[$];
  assign hready = hreadyout;
  sac_acq_ctrl DUT (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .adc_start(adc_start), .adc_entry(adc_entry),
    .adc_done(adc_done), .adc_data(adc_data), .external_timebase_input(external_timebase_input),
    .ext_trigger_input(ext_trigger_input), .mem(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  sac_host_mem host (.clk(clk), .rstn(rstn), .mem(mem), .lag(lag), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .n_wr(n_wr));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function automatic logic [31:0] sx(input int i);
    logic [15:0] c;
    c = 16'(16'h7FFF + i * 16'h4001);
    return {{16{c[15]}}, c};
  endfunction : sx
  function automatic sac_entry_t qent(input int j);
    return '{cfg: sac_icfg_t'(j % 3), gain: sac_gain_t'(j), chan: 4'((j * 5) % 7)};
  endfunction : qent
  // ----------------------------------------
  // converter model, timebase source, start log
  // ----------------------------------------
  always @(posedge clk) begin
    if (!rstn) begin
      cyc <= 0;
      fe <= 3'h0;
      adc_done <= 1'b0;
      adc_data <= 16'h0;
      fe_idx <= 0;
      tbdiv <= 3'h0;
      external_timebase_input <= 1'b0;
    end else begin
      cyc <= cyc + 1;
      fe <= {fe[1:0], adc_start};
      adc_done <= fe[2];
      adc_data <= fe[2] ? 16'(sx(fe_idx)) : ~adc_data;
      if (fe[2]) fe_idx <= fe_idx + 1;
      tbdiv <= tbdiv + 3'h1;
      external_timebase_input <= tbdiv[2];
      if (adc_start === 1'b1) begin
        t_q.push_back(cyc);
        e_q.push_back(adc_entry);
      end
    end
  end
  // ----------------------------------------
  // checking and bus tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  task automatic edge_rdy;
    int i;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (hready !== 1'b1 && i < 20);
    if (hready !== 1'b1) begin
      n_mismatch++;
      wrap_up();
    end
  endtask : edge_rdy
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    edge_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    edge_rdy();
    rd = hrdata;
  endtask : ahb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask : wr
  task automatic wait_q(input int n, input int lim);
    int i;
    i = 0;
    while (t_q.size() < n) begin
      @(posedge clk);
      i++;
      if (i > lim) begin
        n_mismatch++;
        wrap_up();
      end
    end
  endtask : wait_q
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic sc_reset;
    ahb(1'b0, A_STAT, 32'h0);
    chk(rd, 32'h0);
    wr(8'h3C, 32'hFFFFFFFF);
    ahb(1'b0, 8'h3C, 32'h0);
    chk(rd, 32'h0);
  endtask : sc_reset
  task automatic sc_poll;
    int k, i;
    for (k = 0; k < 12; k++) begin
      wr(A_PCFG, 32'(qent(k)));
      wr(A_CTRL, 32'h1 << C_POLL_GO);
      wait_q(k + 1, 20);
      chk(32'(e_q[k]), 32'(qent(k)));
      i = 0;
      do begin
        ahb(1'b0, A_STAT, 32'h0);
        i++;
      end while (rd[1] !== 1'b1 && i < 10);
      chk(32'(rd[1]), 32'h1);
      ahb(1'b0, A_PDATA, 32'h0);
      chk(32'(rd[15:0]), 32'(sx(k) & 32'hFFFF));
      chk(t_q.size(), k + 1);
    end
  endtask : sc_poll
  task automatic sc_scan;
    int b, k;
    b = t_q.size();
    lag <= 4'h3;
    wr(A_SCAN, 640);
    wr(A_SPACE, 160);
    wr(A_POST, 3);
    wr(A_SPS, 4);
    wr(A_QIDX, 0);
    for (k = 0; k < 4; k++) wr(A_QDAT, 32'(qent(k)));
    wr(A_DLO, 32'h40);
    wr(A_DHI, 32'h0);
    wr(A_DSIZE, 64);
    wr(A_CTRL, 32'h1 << C_ARM);
    repeat (100) @(posedge clk);
    chk(t_q.size(), b);
    wr(A_CTRL, 32'h1 << C_SOFT_TRIG);
    wait_q(b + 12, 1000);
    repeat (300) @(posedge clk);
    chk(t_q.size(), b + 12);
    chk(n_wr, 12);
    for (k = 0; k < 12; k++) begin
      chk(32'(e_q[b + k]), 32'(qent(k % 4)));
      chk(t_q[b + k] - t_q[b + k - k % 4], (k % 4) * 40);
      chk(t_q[b + k] - t_q[b + k % 4], (k / 4) * 160);
      chk(host.ram[16 + k], sx(b + k));
    end
    wr(A_CTRL, 32'h1 << C_ABORT);
  endtask : sc_scan
  task automatic sc_chain;
    int b, k;
    logic [31:0] d [8];
    d = '{32'hC0, 32'h0, 32'h1, 32'h90, 32'hD0, 32'h0, 32'h1, 32'h80};
    for (k = 0; k < 8; k++) host.ram[32 + k] = d[k];
    b = t_q.size();
    lag <= 4'h0;
    wr(A_SPACE, 4);
    wr(A_SCAN, 12);
    wr(A_POST, 1);
    wr(A_SPS, 3);
    wr(A_DDESC, 32'h80);
    wr(A_CTRL, 32'hE);
    wr(A_CTRL, 32'hF);
    wr(A_CTRL, 32'h1E);
    repeat (100) @(posedge clk);
    chk(t_q.size(), b);
    ext_trigger_input <= 1'b1;
    repeat (10) @(posedge clk);
    ext_trigger_input <= 1'b0;
    wait_q(b + 3, 500);
    repeat (200) @(posedge clk);
    chk(t_q.size(), b + 3);
    chk(t_q[b + 2] - t_q[b + 1], 32);
    chk(host.ram[52], sx(b + 1));
    chk(host.ram[48], sx(b + 2));
    wr(A_CTRL, 32'h1 << C_ABORT);
  endtask : sc_chain
  initial begin
    rstn = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    hsize = 3'h2;
    ext_trigger_input = 1'b0;
    lag = 4'h0;
    n_mismatch = 0;
    num_checks = 0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    sc_reset();
    sc_poll();
    sc_scan();
    sc_chain();
    wrap_up();
  end
endmodule : sac_acq_ctrl_bench
bind sac_acq_ctrl sac_acq_ctrl_asserts u_chk (.clk(clk), .rstn(rstn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .adc_start(adc_start), .adc_entry(adc_entry), .adc_done(adc_done), .adc_data(adc_data),
  .external_timebase_input(external_timebase_input), .ext_trigger_input(ext_trigger_input),
  .mem(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

// ==== sac_dma.sv ====
// sac_dma: bus-master engine moving converter words to host memory.
// assumes a host memory port that answers each request with a one-cycle ack.
`timescale 1ns/10ps
module sac_dma
  import sac_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic go,
  input wire logic stop,
  input wire logic chain,
  input wire logic [31:0] addr_lo,
  input wire logic [31:0] addr_hi,
  input wire logic [31:0] size,
  input wire logic [31:0] desc_ptr,
  input wire logic fifo_valid,
  input wire logic [15:0] fifo_data,
  output logic fifo_pop,
  output sac_mem_t mem,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output logic busy,
  output logic done,
  output logic [31:0] count
);
  typedef enum logic [1:0] {D_IDLE, D_FETCH, D_XFER} sac_dst_t;
  sac_dst_t st;
  logic [63:0] addr;
  logic [31:0] left;
  logic [31:0] ptr;
  logic [1:0] widx;
  logic last;

  // ----------------------------------------
  // descriptor walk and word transfer
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st <= D_IDLE;
      mem <= '0;
      addr <= '0;
      left <= '0;
      ptr <= '0;
      widx <= '0;
      last <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      count <= '0;
      fifo_pop <= 1'b0;
    end else begin
      fifo_pop <= 1'b0;
      done <= 1'b0;
      if (stop) begin
        st <= D_IDLE;
        mem.req <= 1'b0;
        busy <= 1'b0;
      end else begin
        case (st)
          D_IDLE: begin
            if (go) begin
              busy <= 1'b1;
              count <= '0;
              if (chain) begin
                widx <= '0;
                mem <= '{1'b1, 1'b0, {32'h0, desc_ptr}, 32'h0};
                st <= D_FETCH;
              end else begin
                addr <= {addr_hi, addr_lo};
                left <= (size > 32'(MAX_DWORDS)) ? 32'(MAX_DWORDS) : size;
                last <= 1'b1;
                st <= D_XFER;
              end
            end
          end
          D_FETCH: begin
            if (!mem.req) begin
              // one request per descriptor word, req drops after every ack
              mem.req <= 1'b1;
            end else if (mem_ack) begin
              case (widx)
                2'h0: addr[31:0] <= mem_rdata;
                2'h1: addr[63:32] <= mem_rdata;
                2'h2: left <= mem_rdata;
                default: begin
                  ptr <= mem_rdata;
                  last <= mem_rdata[0];
                end
              endcase
              mem.req <= 1'b0;
              if (widx == DESC_LAST) begin
                st <= D_XFER;
              end else begin
                widx <= widx + 2'h1;
                mem.addr <= mem.addr + WORD_BYTES;
              end
            end
          end
          D_XFER: begin
            if (mem.req) begin
              if (mem_ack) begin
                mem.req <= 1'b0;
                addr <= addr + WORD_BYTES;
                left <= left - 32'h1;
                count <= count + 32'h1;
              end
            end else if (left == 32'h0) begin
              if (last) begin
                st <= D_IDLE;
                busy <= 1'b0;
                done <= 1'b1;
              end else begin
                widx <= '0;
                mem <= '{1'b1, 1'b0, {32'h0, ptr[31:1], 1'b0}, 32'h0};
                st <= D_FETCH;
              end
            end else if (fifo_valid && !fifo_pop) begin
              fifo_pop <= 1'b1;
              mem <= '{1'b1, 1'b1, addr, {{16{fifo_data[15]}}, fifo_data}};
            end
          end
          default: st <= D_IDLE;
        endcase
      end
    end
  end
endmodule : sac_dma

// ==== sac_host_mem.sv ====
// sac_host_mem: host memory answering the bus-master port of the block.
// assumes requests hold until ack; lag sets extra wait cycles.
`timescale 1ns/10ps
module sac_host_mem
  import sac_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire sac_mem_t mem,
  input wire logic [3:0] lag,
  output logic mem_ack,
  output logic [31:0] mem_rdata,
  output int n_wr
);
  logic [31:0] ram [0:63];
  int wait_c;
  // idle read data keeps toggling so stale values are never mistaken
  always @(posedge clk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (!rstn) begin
      wait_c <= 0;
      n_wr <= 0;
      mem_rdata <= 32'h0;
    end else if (mem.req && !mem_ack) begin
      if (wait_c >= int'(lag)) begin
        mem_ack <= 1'b1;
        wait_c <= 0;
        if (mem.we) begin
          ram[mem.addr[7:2]] <= mem.wdata;
          n_wr <= n_wr + 1;
        end else begin
          mem_rdata <= ram[mem.addr[7:2]];
        end
      end else begin
        wait_c <= wait_c + 1;
      end
    end
  end
endmodule : sac_host_mem

// ==== sac_pkg.sv ====
// sac_pkg: shared constants and types of the scan acquisition controller.
// assumes a 10 MHz system clock and a 32-bit AHB-Lite register bus.
package sac_pkg;
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_PCFG = 8'h04;
  localparam logic [7:0] A_PDATA = 8'h08;
  localparam logic [7:0] A_STAT = 8'h0C;
  localparam logic [7:0] A_SCAN = 8'h10;
  localparam logic [7:0] A_SPACE = 8'h14;
  localparam logic [7:0] A_POST = 8'h18;
  localparam logic [7:0] A_SPS = 8'h1C;
  localparam logic [7:0] A_QIDX = 8'h20;
  localparam logic [7:0] A_QDAT = 8'h24;
  localparam logic [7:0] A_DLO = 8'h28;
  localparam logic [7:0] A_DHI = 8'h2C;
  localparam logic [7:0] A_DSIZE = 8'h30;
  localparam logic [7:0] A_DDESC = 8'h34;
  localparam logic [7:0] A_DCNT = 8'h38;
  // ----------------------------------------
  // control bit positions
  // ----------------------------------------
  localparam int C_ARM = 0;
  localparam int C_TRIG_EXT = 1;
  localparam int C_TB_EXT = 2;
  localparam int C_CHAIN = 3;
  localparam int C_SOFT_TRIG = 4;
  localparam int C_POLL_GO = 5;
  localparam int C_ABORT = 6;
  // ----------------------------------------
  // timing and sizes
  // ----------------------------------------
  localparam longint CLK_HZ = 10000000;
  localparam longint INT_TB_HZ = 40000000;
  localparam logic [2:0] INT_STEP = 3'(INT_TB_HZ / CLK_HZ);
  localparam logic [22:0] MAX_DWORDS = 23'h200000;
  localparam int FIFO_AW = 4;
  localparam logic [63:0] WORD_BYTES = 64'h4;
  localparam logic [1:0] DESC_LAST = 2'h3;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    referenced_single_ended, nonreferenced_single_ended, differential_input
  } sac_icfg_t;
  typedef enum logic [1:0] {range_5v, range_1v, range_0p5v, range_0p2v} sac_gain_t;
  typedef struct packed {
    sac_icfg_t cfg;
    sac_gain_t gain;
    logic [3:0] chan;
  } sac_entry_t;
  typedef struct packed {
    logic req;
    logic we;
    logic [63:0] addr;
    logic [31:0] wdata;
  } sac_mem_t;
endpackage : sac_pkg
